// File: rtl/eepc_pkg.sv
// constants and types shared by the eeprom page-buffer controller
package eepc_pkg;

    // ------------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------------
    localparam int EE_ADDR_W = 9;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int EE_BYTES = 512;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    typedef logic [PAGE_W-1:0] eepc_idx_t;
    typedef logic [EE_ADDR_W-PAGE_W-1:0] eepc_page_t;

    // ------------------------------------------------------------------
    // register byte offsets (low 14 bits of haddr are decoded)
    // ------------------------------------------------------------------
    localparam logic [13:0] OFF_ADDR = 14'h0000;
    localparam logic [13:0] OFF_DATA_LOW = 14'h0004;
    localparam logic [13:0] OFF_CMD = 14'h0008;
    localparam logic [13:0] OFF_CTRL1 = 14'h000C;
    localparam logic [13:0] OFF_CTRL2 = 14'h0010;
    localparam logic [13:0] OFF_IRQ_CTRL = 14'h0014;
    localparam logic [13:0] OFF_STATUS = 14'h0018;
    localparam logic [13:0] OFF_PROT = 14'h001C;
    // data-space window: 0x1000..0x17FC, one eeprom byte per word
    localparam logic [2:0] MAP_TAG = 3'h2;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int EXEC_BIT = 0;
    localparam int MAP_EN_BIT = 3;
    localparam int STAT_LOAD_BIT = 1;
    localparam int STAT_BUSY_BIT = 7;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [1:0] LVL_RST = 2'h0;

    // ------------------------------------------------------------------
    // command codes and protection
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ = 8'h06;
    localparam logic [7:0] CMD_ERASE = 8'h32;
    localparam logic [7:0] CMD_LOAD = 8'h33;
    localparam logic [7:0] CMD_SPLIT = 8'h34;
    localparam logic [7:0] CMD_ATOMIC = 8'h35;
    localparam logic [7:0] CMD_FLUSH = 8'h36;
    localparam logic [7:0] PROT_SIG = 8'hD8;
    localparam logic [2:0] PROT_WIN_CYC = 3'h4;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int OP_TIME_NS = 4000;
    localparam logic [8:0] OP_CYC = 9'((OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] READ_STALL = 2'h2;
    localparam logic [1:0] LOAD_STALL = 2'h1;
    localparam logic [1:0] REG_RD_STALL = 2'h1;

    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE} eepc_op_e;

    typedef struct packed {
        logic wr;
        logic [13:0] addr;
    } eepc_aph_s;

endpackage : eepc_pkg

// File: rtl/eepc_ctrl.sv
// eeprom page-buffer controller with ahb-lite register slave
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module eepc_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // system side
    input wire logic otherBusy,
    input wire logic cpuSleep,
    input wire logic dmaEeReq,
    output logic busyOut,
    output logic irqReq,
    output logic dmaAbort
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] eeMem [eepc_pkg::EE_BYTES];
    logic [7:0] pageBuf_r [eepc_pkg::PAGE_BYTES];
    logic [eepc_pkg::PAGE_BYTES-1:0] pageTag_r;
    logic loadFlag_r;

    // registers
    logic [15:0] addr_r;
    logic [7:0] dataLow_r;
    logic [7:0] cmd_r;
    logic mapEn_r;
    logic [1:0] irqLvl_r;
    logic [2:0] protCnt_r;

    // operation engine
    eepc_pkg::eepc_op_e opState_r;
    logic [8:0] opCnt_r;
    logic opAtomic_r;
    eepc_pkg::eepc_page_t opPage_r;
    logic [9:0] opElapsed_r;

    // bus slave
    eepc_pkg::eepc_aph_s dph_r;
    logic dphValid_r;
    logic [1:0] stall_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic busyOut_r;
    logic irqReq_r;
    logic dmaAbort_r;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic accept;
    logic busyNow;
    logic wrDone;
    logic regWrOk;
    logic protOpen;
    logic execFire;
    logic mapHit;
    logic ioLoad;
    logic mapLoad;
    logic loadFire;
    eepc_pkg::eepc_idx_t loadIdx;
    logic [7:0] loadData;
    logic [7:0] loadExp;
    logic opStart;
    logic opEnd;
    logic [1:0] stallN;
    logic [31:0] rdMux;

    assign accept = hsel && htrans[1] && hreadyout_r;
    assign busyNow = (opState_r != eepc_pkg::OP_IDLE) || otherBusy;
    assign wrDone = dphValid_r && hreadyout_r && dph_r.wr;
    assign regWrOk = wrDone && !busyNow;
    assign protOpen = (protCnt_r != 3'h0);
    assign execFire = regWrOk && (dph_r.addr == eepc_pkg::OFF_CTRL1)
        && hwdata[eepc_pkg::EXEC_BIT] && protOpen;
    assign mapHit = (dph_r.addr[13:11] == eepc_pkg::MAP_TAG);
    assign ioLoad = regWrOk && (dph_r.addr == eepc_pkg::OFF_DATA_LOW)
        && (cmd_r == eepc_pkg::CMD_LOAD) && !mapEn_r;
    assign mapLoad = regWrOk && mapHit && mapEn_r;
    assign loadFire = ioLoad || mapLoad;
    assign loadIdx = ioLoad ? addr_r[eepc_pkg::PAGE_W-1:0] : dph_r.addr[6:2];
    assign loadData = hwdata[7:0];
    assign loadExp = pageTag_r[loadIdx] ? (pageBuf_r[loadIdx] & loadData) : loadData;
    assign opStart = execFire && ((cmd_r == eepc_pkg::CMD_ERASE)
        || (cmd_r == eepc_pkg::CMD_SPLIT) || (cmd_r == eepc_pkg::CMD_ATOMIC));
    assign opEnd = (opState_r == eepc_pkg::OP_WRITE) && (opCnt_r == 9'h000);

    // stall length picked in the address phase; data is not known yet, so a
    // read-command stall is taken even if the execute bit turns out clear
    always_comb begin
        stallN = 2'h0;
        if (!hwrite) begin
            stallN = eepc_pkg::REG_RD_STALL;
        end else if ((haddr[13:0] == eepc_pkg::OFF_DATA_LOW) && (cmd_r == eepc_pkg::CMD_LOAD)
                && !mapEn_r && !busyNow) begin
            stallN = eepc_pkg::LOAD_STALL;
        end else if ((haddr[13:0] == eepc_pkg::OFF_CTRL1) && (cmd_r == eepc_pkg::CMD_READ)
                && !mapEn_r && !busyNow && protOpen) begin
            stallN = eepc_pkg::READ_STALL;
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        case (dph_r.addr)
            eepc_pkg::OFF_ADDR: rdMux[15:0] = addr_r;
            eepc_pkg::OFF_DATA_LOW: rdMux[7:0] = dataLow_r;
            eepc_pkg::OFF_CMD: rdMux[7:0] = cmd_r;
            eepc_pkg::OFF_CTRL2: rdMux[eepc_pkg::MAP_EN_BIT] = mapEn_r;
            eepc_pkg::OFF_IRQ_CTRL: rdMux[1:0] = irqLvl_r;
            eepc_pkg::OFF_STATUS: begin
                rdMux[eepc_pkg::STAT_BUSY_BIT] = busyNow;
                rdMux[eepc_pkg::STAT_LOAD_BIT] = loadFlag_r;
            end
            default: begin
                if (mapHit && mapEn_r && !busyNow) begin
                    rdMux[7:0] = eeMem[dph_r.addr[10:2]];
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // ahb-lite slave: every read takes one wait state so it sees the
    // effect of a write completing at its own address-phase edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dphValid_r <= 1'b0;
            dph_r <= '0;
            stall_r <= 2'h0;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
            hresp_r <= 1'b0;
        end else if (accept) begin
            dphValid_r <= 1'b1;
            dph_r <= '{wr: hwrite, addr: haddr[13:0]};
            stall_r <= stallN;
            hreadyout_r <= (stallN == 2'h0);
        end else begin
            if (dphValid_r && hreadyout_r) begin
                dphValid_r <= 1'b0;
            end
            if (!hreadyout_r) begin
                stall_r <= stall_r - 2'h1;
                if (stall_r == 2'h1) begin
                    hreadyout_r <= 1'b1;
                    if (!dph_r.wr) begin
                        hrdata_r <= rdMux;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // protection window
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            protCnt_r <= 3'h0;
        end else if (wrDone && (dph_r.addr == eepc_pkg::OFF_PROT)
                && (hwdata[7:0] == eepc_pkg::PROT_SIG)) begin
            protCnt_r <= eepc_pkg::PROT_WIN_CYC;
        end else if (protOpen) begin
            protCnt_r <= protCnt_r - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_r <= eepc_pkg::ADDR_RST;
            dataLow_r <= eepc_pkg::DATA_RST;
            cmd_r <= eepc_pkg::CMD_RST;
            mapEn_r <= 1'b0;
            irqLvl_r <= eepc_pkg::LVL_RST;
        end else begin
            if (regWrOk && (dph_r.addr == eepc_pkg::OFF_ADDR)) begin
                addr_r <= hwdata[15:0];
            end
            if (regWrOk && (dph_r.addr == eepc_pkg::OFF_CMD)) begin
                cmd_r <= hwdata[7:0];
            end
            if (regWrOk && (dph_r.addr == eepc_pkg::OFF_DATA_LOW)) begin
                dataLow_r <= hwdata[7:0];
            end else if (execFire && (cmd_r == eepc_pkg::CMD_READ) && !mapEn_r) begin
                dataLow_r <= eeMem[addr_r[eepc_pkg::EE_ADDR_W-1:0]];
            end
            if (wrDone && (dph_r.addr == eepc_pkg::OFF_CTRL2)) begin
                mapEn_r <= hwdata[eepc_pkg::MAP_EN_BIT];
            end
            if (wrDone && (dph_r.addr == eepc_pkg::OFF_IRQ_CTRL)) begin
                irqLvl_r <= hwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // page buffer
    // ------------------------------------------------------------------
    // buffer data carries no reset; tags decide whether it means anything
    always_ff @(posedge clk) begin
        if (loadFire) begin
            pageBuf_r[loadIdx] <= loadExp;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pageTag_r <= '0;
            loadFlag_r <= 1'b0;
        end else if (loadFire) begin
            pageTag_r[loadIdx] <= 1'b1;
            loadFlag_r <= 1'b1;
        end else if ((execFire && (cmd_r == eepc_pkg::CMD_FLUSH)) || opEnd) begin
            pageTag_r <= '0;
            loadFlag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // erase / write engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            opState_r <= eepc_pkg::OP_IDLE;
            opCnt_r <= 9'h000;
            opAtomic_r <= 1'b0;
            opPage_r <= '0;
        end else begin
            case (opState_r)
                eepc_pkg::OP_IDLE: begin
                    if (opStart) begin
                        opPage_r <= addr_r[eepc_pkg::EE_ADDR_W-1:eepc_pkg::PAGE_W];
                        opAtomic_r <= (cmd_r == eepc_pkg::CMD_ATOMIC);
                        opCnt_r <= eepc_pkg::OP_CYC - 9'h001;
                        opState_r <= (cmd_r == eepc_pkg::CMD_SPLIT) ? eepc_pkg::OP_WRITE
                            : eepc_pkg::OP_ERASE;
                    end
                end
                eepc_pkg::OP_ERASE: begin
                    if (opCnt_r != 9'h000) begin
                        opCnt_r <= opCnt_r - 9'h001;
                    end else if (opAtomic_r) begin
                        opCnt_r <= eepc_pkg::OP_CYC - 9'h001;
                        opState_r <= eepc_pkg::OP_WRITE;
                    end else begin
                        opState_r <= eepc_pkg::OP_IDLE;
                    end
                end
                eepc_pkg::OP_WRITE: begin
                    if (opCnt_r != 9'h000) begin
                        opCnt_r <= opCnt_r - 9'h001;
                    end else begin
                        opState_r <= eepc_pkg::OP_IDLE;
                    end
                end
                default: opState_r <= eepc_pkg::OP_IDLE;
            endcase
        end
    end

    // array update at the end of each phase, all tagged bytes of the page in one edge
    always_ff @(posedge clk) begin
        for (int i = 0; i < eepc_pkg::PAGE_BYTES; i++) begin
            if (pageTag_r[i]) begin
                if ((opState_r == eepc_pkg::OP_ERASE) && (opCnt_r == 9'h000)) begin
                    eeMem[{opPage_r, eepc_pkg::eepc_idx_t'(i)}] <= eepc_pkg::ERASED_BYTE;
                end else if (opEnd) begin
                    eeMem[{opPage_r, eepc_pkg::eepc_idx_t'(i)}] <=
                        eeMem[{opPage_r, eepc_pkg::eepc_idx_t'(i)}] & pageBuf_r[i];
                end
            end
        end
    end

    // elapsed busy cycles, used only by the checks below
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            opElapsed_r <= 10'h000;
        end else if (opStart) begin
            opElapsed_r <= 10'h000;
        end else if (opState_r != eepc_pkg::OP_IDLE) begin
            opElapsed_r <= opElapsed_r + 10'h001;
        end
    end

    // ------------------------------------------------------------------
    // system outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busyOut_r <= 1'b0;
            irqReq_r <= 1'b0;
            dmaAbort_r <= 1'b0;
        end else begin
            busyOut_r <= busyNow;
            irqReq_r <= (irqLvl_r != 2'h0) && !busyNow;
            dmaAbort_r <= dmaEeReq && cpuSleep;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign busyOut = busyOut_r;
    assign irqReq = irqReq_r;
    assign dmaAbort = dmaAbort_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    localparam int ATOMIC_LAST = 2 * eepc_pkg::OP_CYC - 1;

    AST_BUSY_EXT: assert property (@(posedge clk) disable iff (sys_rst)
        otherBusy |=> busyOut_r)
        else $error("busy output missed external busy");

    AST_EXEC_WINDOW: assert property (@(posedge clk) disable iff (sys_rst)
        opStart |-> (protCnt_r != 3'h0) && ($past(protCnt_r) != 3'h0 || $past(wrDone)))
        else $error("operation started outside protection window");

    AST_DONE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        opEnd |=> (opState_r == eepc_pkg::OP_IDLE) && !loadFlag_r && (pageTag_r == '0))
        else $error("page write end did not release busy and buffer");

    AST_ATOMIC_TIME: assert property (@(posedge clk) disable iff (sys_rst)
        (opEnd && opAtomic_r) |-> (opElapsed_r == 10'(ATOMIC_LAST)))
        else $error("atomic write length is not twice a single phase");

    AST_LOAD_AND: assert property (@(posedge clk) disable iff (sys_rst)
        (loadFire && pageTag_r[loadIdx]) |=> (pageBuf_r[$past(loadIdx)] == $past(loadExp))
            && ($past(loadExp) == ($past(loadData) & $past(loadExp)))
            && pageTag_r[$past(loadIdx)])
        else $error("reloaded buffer byte is not the and of old and new");

    AST_READ_STALL: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && hwrite && (stallN == eepc_pkg::READ_STALL))
            |=> !hreadyout_r ##1 !hreadyout_r ##1 hreadyout_r)
        else $error("read command did not stall exactly two cycles");

    AST_LOAD_STALL: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && hwrite && (haddr[13:0] == eepc_pkg::OFF_DATA_LOW)
            && (stallN == eepc_pkg::LOAD_STALL)) |=> !hreadyout_r ##1 hreadyout_r)
        else $error("buffer load did not stall exactly one cycle");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
        ((irqLvl_r != 2'h0) && !busyNow) |=> irqReq_r)
        else $error("interrupt not requested while idle");

    AST_DMA_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
        (dmaEeReq && cpuSleep) |=> dmaAbort_r)
        else $error("dma access in sleep not aborted");

    AST_MAP_NOREAD: assert property (@(posedge clk) disable iff (sys_rst)
        (execFire && (cmd_r == eepc_pkg::CMD_READ) && mapEn_r) |=> $stable(dataLow_r))
        else $error("register read ran in mapped mode");

    AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (sys_rst)
        busyNow |-> !opStart && !loadFire)
        else $error("command or load accepted while busy");

    AST_FLUSH: assert property (@(posedge clk) disable iff (sys_rst)
        (execFire && (cmd_r == eepc_pkg::CMD_FLUSH)) |=> (pageTag_r == '0) && !loadFlag_r)
        else $error("flush left tags or loading flag set");

    AST_LOAD_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
        loadFire |=> loadFlag_r && $stable(opState_r))
        else $error("loading flag not raised by a load");

endmodule : eepc_ctrl

// File: dv/eepc_sys_model.sv
// system-side partner: foreign controller work and a sleeping-cpu dma master
`timescale 1ns/1ps
module eepc_sys_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // bench control
    input wire logic busyKick,
    input wire logic sleepReq,
    // to controller
    output logic otherBusy,
    output logic cpuSleep,
    output logic dmaEeReq
);
    logic [5:0] cnt_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 6'h00;
        end else if (busyKick) begin
            cnt_r <= 6'h28;
        end else if (cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end
    assign otherBusy = (cnt_r != 6'h00);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpuSleep <= 1'b0;
            dmaEeReq <= 1'b0;
        end else begin
            cpuSleep <= sleepReq;
            dmaEeReq <= sleepReq;
        end
    end
endmodule : eepc_sys_model

// File: dv/eeprom_page_buffer_controller_tb.sv
// self-checking bench for the eeprom page-buffer controller
`timescale 1ns/1ps
module eeprom_page_buffer_controller_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, otherBusy, cpuSleep, dmaEeReq, busyOut, irqReq, dmaAbort;
    logic busyKick = 1'b0;
    logic sleepReq = 1'b0;
    int errorCnt = 0;
    int numChecks = 0;
    int cycles = 0;
    int na, ns, nx;

    eepc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .otherBusy(otherBusy),
        .cpuSleep(cpuSleep), .dmaEeReq(dmaEeReq), .busyOut(busyOut), .irqReq(irqReq),
        .dmaAbort(dmaAbort));
    eepc_sys_model sys (.clk(clk), .sys_rst(sys_rst), .busyKick(busyKick),
        .sleepReq(sleepReq), .otherBusy(otherBusy), .cpuSleep(cpuSleep), .dmaEeReq(dmaEeReq));

    always #12.5 clk = ~clk;

    task automatic completeRun();
        if (errorCnt == 0 && numChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : completeRun

    // hang guard: the whole sequence needs about 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            completeRun();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // --------------------------------------------------------------
    // ahb-lite single word transfers
    // --------------------------------------------------------------
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {18'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [13:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rd

    task automatic waitIdle(output int n);
        n = 0;
        while (busyOut !== 1'b0) begin
            @(posedge clk);
            n++;
        end
    endtask : waitIdle

    // unlock then execute; busy is given a few edges to show
    task automatic op(input logic [7:0] c, output int n);
        wr(eepc_pkg::OFF_CMD, {24'h0, c});
        wr(eepc_pkg::OFF_PROT, {24'h0, eepc_pkg::PROT_SIG});
        wr(eepc_pkg::OFF_CTRL1, 32'h1);
        n = 0;
        while (busyOut !== 1'b1 && n < 4) begin
            @(posedge clk);
            n++;
        end
        waitIdle(n);
    endtask : op

    task automatic readByte(input string nm, input logic [31:0] e);
        op(eepc_pkg::CMD_READ, nx);
        rd(nm, eepc_pkg::OFF_DATA_LOW, e);
    endtask : readByte

    task automatic load(input logic [31:0] d);
        wr(eepc_pkg::OFF_CMD, {24'h0, eepc_pkg::CMD_LOAD});
        wr(eepc_pkg::OFF_DATA_LOW, d);
    endtask : load

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd("status", eepc_pkg::OFF_STATUS, 32'h0);
        rd("unmapped", 14'h0020, 32'h0);
        wr(eepc_pkg::OFF_ADDR, 32'h01E5);
        load(32'hF0);
        wr(eepc_pkg::OFF_DATA_LOW, 32'h5F);
        rd("loadFlag", eepc_pkg::OFF_STATUS, 32'h02);
        wr(eepc_pkg::OFF_ADDR, 32'h003F);
        op(eepc_pkg::CMD_ATOMIC, na);
        rd("loadClr", eepc_pkg::OFF_STATUS, 32'h0);
        wr(eepc_pkg::OFF_ADDR, 32'h0025);
        readByte("atomic", 32'h50);
        load(32'h1F);
        op(eepc_pkg::CMD_SPLIT, ns);
        readByte("split", 32'h10);
        chk("splitCyc", {23'h0, eepc_pkg::OP_CYC}, ns);
        chk("atomCyc", 32'(2 * ns), 32'(na));
        load(32'h00);
        op(eepc_pkg::CMD_ERASE, nx);
        rd("eraseKeeps", eepc_pkg::OFF_STATUS, 32'h02);
        readByte("erase", 32'hFF);
        op(eepc_pkg::CMD_FLUSH, nx);
        rd("flush", eepc_pkg::OFF_STATUS, 32'h0);
        wr(eepc_pkg::OFF_CMD, {24'h0, eepc_pkg::CMD_ERASE});
        wr(eepc_pkg::OFF_CTRL1, 32'h1);
        rd("noUnlock", eepc_pkg::OFF_STATUS, 32'h0);
        wr(eepc_pkg::OFF_CTRL2, 32'h08);
        waitIdle(nx);
        rd("mapped", 14'h1094, 32'hFF);
        wr(14'h1094, 32'h0F);
        rd("mapLoad", eepc_pkg::OFF_STATUS, 32'h02);
        op(eepc_pkg::CMD_FLUSH, nx);
        wr(eepc_pkg::OFF_ADDR, 32'h0024);
        readByte("mapNoRead", 32'hFF);
        wr(eepc_pkg::OFF_ADDR, 32'h0025);
        wr(eepc_pkg::OFF_CTRL2, 32'h0);
        wr(eepc_pkg::OFF_IRQ_CTRL, 32'h1);
        busyKick <= 1'b1;
        @(posedge clk);
        busyKick <= 1'b0;
        rd("foreign", eepc_pkg::OFF_STATUS, 32'h80);
        chk("irqBusy", 32'h0, {31'h0, irqReq});
        wr(eepc_pkg::OFF_ADDR, 32'h0000);
        waitIdle(nx);
        rd("idle", eepc_pkg::OFF_STATUS, 32'h0);
        chk("irqIdle", 32'h1, {31'h0, irqReq});
        readByte("keptAddr", 32'hFF);
        sleepReq <= 1'b1;
        repeat (3) @(posedge clk);
        chk("dmaAbort", 32'h1, {31'h0, dmaAbort});
        sleepReq <= 1'b0;
        repeat (3) @(posedge clk);
        chk("dmaQuiet", 32'h0, {31'h0, dmaAbort});
        completeRun();
    end
endmodule : eeprom_page_buffer_controller_tb
